// >>> src/three_band_fir_judge.sv
`timescale 1ns/100ps
// Functional notes
// - Sample store has two blocks; filter reads one while the other fills.
// - Block-complete event swaps the filled and the read block when the filter is idle.
// - Completion handling happens first, filtering of the finished block follows.
// - Handler sets update flag; filter side rewrites pending descriptor, clears flag.
// - Update flag is cleared by the filter side during initialization.
// - Handler copies pending descriptor into active one when the filter is idle, and restarts filling.
// - Pending descriptor starts at block one element zero, count 256.
// - Active descriptor starts at block zero element zero, count 256.
// - Init order: routing, coefficient load, handshake setup, then transfer enable.
// - Default mode: 12-bit unsigned sample becomes 15-bit signed, bias then scale.
// - Integer mode: sample becomes 31-bit signed within plus/minus two to thirty.
// - Float mode: sample becomes single-precision value between -1.0 and 1.0.
// - Three channels share the block: low-pass, band-pass, high-pass, own stores.
// - Each run takes 256 signed 16-bit inputs, gives signed 16-bit outputs.
// - Per channel and block: sum of absolute outputs divided by 256.
// - At 10 kHz with 256-sample blocks about 40 averages per second.
// - After 40 blocks, sum averages, compare, largest channel is the band.
// - Low: a on b off; mid: a off b on; high: both on; none: both off.
// - Each button press toggles filtering on and off.
// - Source select 1 feeds stored waveform instead of converter samples.
// - Low-pass coefficient set has its cutoff at 500 Hz.
// - Band-pass coefficient set is centred at 1,500 Hz.
// - High-pass coefficient set has its cutoff at 3,000 Hz.
// - 64 taps per channel by default, power of two from 64 to 256.
module three_band_fir_judge #(
    parameter int TAPS = three_band_pkg::DEFAULT_TAPS
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [three_band_pkg::SAMPLE_W-1:0] sample_data,
    output logic sample_ready,
    input wire logic source_select,
    input wire three_band_pkg::norm_mode_t norm_mode,
    input wire logic coef_wr,
    input wire logic [three_band_pkg::CH_W-1:0] coef_ch,
    input wire logic [7:0] coef_idx,
    input wire logic signed [three_band_pkg::NORM_W-1:0] coef_data,
    input wire logic coef_load_done,
    input wire logic filter_toggle_button,
    input wire logic [three_band_pkg::CH_W-1:0] res_rd_ch,
    input wire logic [three_band_pkg::BLOCK_SHIFT-1:0] res_rd_idx,
    output logic [three_band_pkg::NORM_W-1:0] res_rd_data,
    output logic [three_band_pkg::WORD_W-1:0] norm_word,
    output logic norm_valid,
    output logic filter_on,
    output logic overrun,
    output logic band_indicator_a,
    output logic band_indicator_b
);
    import three_band_pkg::*;

    localparam int TAP_W = $clog2(TAPS);

    typedef enum {ST_INIT, ST_IDLE, ST_UPDATE, ST_LOAD, ST_MAC, ST_STORE,
        ST_BLOCKEND, ST_JUDGE} state_t;

    state_t st_r;
    logic xfer_en_r;
    logic [ADDR_W-1:0] cur_base_r, next_base_r, job_base_r;
    logic [IDX_W-1:0] cur_cnt_r, next_cnt_r, fill_idx_r;
    logic update_req_r, job_pend_r;
    logic [WAVE_W-1:0] wave_idx_r;
    logic [SAMPLE_W-1:0] input_store [2*BLOCK_LEN];
    logic [SAMPLE_W-1:0] src_sample, rd_sample;
    logic block_done, blk_take;
    logic [BLOCK_SHIFT-1:0] n_r;
    logic [TAP_W-1:0] k_r;
    logic [BLK_CNT_W-1:0] blk_cnt_r;
    logic signed [NORM_W-1:0] hist_r [TAPS];
    logic signed [SAMPLE_W:0] diff;
    logic [SAMPLE_W-1:0] mag;
    logic btn_s1_r, btn_s2_r, btn_s3_r, btn_rise;
    logic filter_on_r;
    logic overrun_r;
    band_t band_r;
    logic [TOTAL_W-1:0] total [NUM_CH];
    logic [NORM_W-1:0] rd_word [NUM_CH];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Transfer side: fill the active block, handler work on the last sample
    assign sample_ready = xfer_en_r;
    assign src_sample = (source_select == SRC_STORED) ? WAVE_TABLE[wave_idx_r] : sample_data;
    assign block_done = sample_valid && xfer_en_r && (fill_idx_r == cur_cnt_r - 9'h001);
    // A block ending while the previous one is still filtered is dropped: filling
    // restarts in the same block, so the block being read is never overwritten
    assign blk_take = block_done && st_r == ST_IDLE && !job_pend_r;

    always_ff @(posedge clk_sys) begin
        if (sample_valid && xfer_en_r) begin
            input_store[ADDR_W'(cur_base_r + fill_idx_r)] <= src_sample;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fill_idx_r <= '0;
            wave_idx_r <= '0;
        end else if (sample_valid && xfer_en_r) begin
            wave_idx_r <= wave_idx_r + 1'b1;
            fill_idx_r <= block_done ? '0 : fill_idx_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_base_r <= CUR_BASE_RST;
            cur_cnt_r <= DESC_CNT_RST;
            job_base_r <= NEXT_BASE_RST;
        end else if (blk_take) begin
            cur_base_r <= next_base_r;
            cur_cnt_r <= next_cnt_r;
            job_base_r <= cur_base_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            update_req_r <= 1'b0;
        end else if (block_done) begin
            update_req_r <= 1'b1;
        end else if (st_r == ST_INIT || st_r == ST_UPDATE) begin
            update_req_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            job_pend_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            overrun_r <= block_done && (job_pend_r || (st_r != ST_IDLE));
            if (block_done && st_r == ST_IDLE) begin
                job_pend_r <= 1'b1;
            end else if (st_r == ST_UPDATE) begin
                job_pend_r <= 1'b0;
            end
        end
    end

    // Pending descriptor points at the block just finished, ready for the next swap
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            next_base_r <= NEXT_BASE_RST;
            next_cnt_r <= DESC_CNT_RST;
        end else if (st_r == ST_UPDATE && update_req_r) begin
            next_base_r <= cur_base_r ^ BLOCK_SEL;
            next_cnt_r <= IDX_W'(BLOCK_LEN);
        end
    end

    // Button: two-flop synchroniser, then a press detector
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
            btn_s3_r <= 1'b0;
        end else begin
            btn_s1_r <= filter_toggle_button;
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
        end
    end
    assign btn_rise = btn_s2_r && !btn_s3_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            filter_on_r <= 1'b1;
        end else if (btn_rise) begin
            filter_on_r <= !filter_on_r;
        end
    end

    // Sequencer: init, descriptor service, then per-sample load, MAC, store
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_INIT;
            xfer_en_r <= 1'b0;
        end else begin
            case (st_r)
                ST_INIT: begin
                    if (coef_load_done) begin
                        xfer_en_r <= 1'b1;
                        st_r <= ST_IDLE;
                    end
                end
                ST_IDLE: if (job_pend_r) st_r <= ST_UPDATE;
                ST_UPDATE: st_r <= ST_LOAD;
                ST_LOAD: st_r <= ST_MAC;
                ST_MAC: if (k_r == TAP_W'(TAPS - 1)) st_r <= ST_STORE;
                ST_STORE: st_r <= (n_r == BLOCK_SHIFT'(BLOCK_LEN - 1)) ? ST_BLOCKEND : ST_LOAD;
                ST_BLOCKEND: begin
                    st_r <= (blk_cnt_r == BLK_CNT_W'(BLOCKS_PER_DECISION - 1)) ?
                        ST_JUDGE : ST_IDLE;
                end
                ST_JUDGE: st_r <= ST_IDLE;
                default: st_r <= ST_INIT;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            n_r <= '0;
            k_r <= '0;
        end else begin
            if (st_r == ST_UPDATE) n_r <= '0;
            else if (st_r == ST_STORE) n_r <= n_r + 1'b1;
            k_r <= (st_r == ST_MAC) ? k_r + 1'b1 : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            blk_cnt_r <= '0;
        end else if (st_r == ST_JUDGE) begin
            blk_cnt_r <= '0;
        end else if (st_r == ST_BLOCKEND) begin
            blk_cnt_r <= blk_cnt_r + 1'b1;
        end
    end

    // Normalisation of the sample being read
    assign rd_sample = input_store[ADDR_W'(job_base_r + ADDR_W'(n_r))];
    assign diff = $signed({1'b0, rd_sample}) - $signed({1'b0, ADC_BIAS});
    assign mag = diff[SAMPLE_W] ? SAMPLE_W'(-diff) : diff[SAMPLE_W-1:0];

    function automatic logic [WORD_W-1:0] to_f32(input logic sgn,
                                                input logic [SAMPLE_W-1:0] m);
        logic [3:0] p;
        logic [34:0] sh;
        p = '0;
        for (int i = 0; i < SAMPLE_W; i++) begin
            if (m[i]) p = 4'(i);
        end
        sh = {23'h0, m} << (5'd23 - 5'(p));
        if (m == '0) return '0;
        return {sgn, 8'(F32_EXP_ONE + 8'(p) - 8'(SAMPLE_W - 1)), sh[22:0]};
    endfunction : to_f32

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            norm_word <= '0;
            norm_valid <= 1'b0;
        end else begin
            norm_valid <= (st_r == ST_LOAD);
            if (st_r == ST_LOAD) begin
                case (norm_mode)
                    NORM_I32: norm_word <= WORD_W'(diff) <<< NORM_SHIFT32;
                    NORM_F32: norm_word <= to_f32(diff[SAMPLE_W], mag);
                    default: norm_word <= WORD_W'(NORM_W'(diff) <<< NORM_SHIFT16);
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int t = 0; t < TAPS; t++) hist_r[t] <= '0;
        end else if (st_r == ST_LOAD) begin
            hist_r[0] <= NORM_W'(diff) <<< NORM_SHIFT16;
            for (int t = 1; t < TAPS; t++) hist_r[t] <= hist_r[t-1];
        end
    end

    // Per channel: coefficients, MAC, result store, block and window sums
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic signed [NORM_W-1:0] coef_mem [TAPS];
        logic [NORM_W-1:0] res_mem [BLOCK_LEN];
        logic signed [ACC_W-1:0] acc_r, acc_sh;
        logic signed [NORM_W-1:0] y;
        logic [NORM_W-1:0] y_abs;
        logic [SUM_W-1:0] blk_sum_r;
        logic [TOTAL_W-1:0] total_r;
        logic [NORM_W-1:0] rd_r;

        assign acc_sh = acc_r >>> COEF_FRAC;
        always_comb begin
            if (!filter_on_r) y = hist_r[0];
            else if (acc_sh > ACC_W'($signed(SAT_POS))) y = SAT_POS;
            else if (acc_sh < -ACC_W'($signed({1'b0, SAT_NEG}))) y = SAT_NEG;
            else y = NORM_W'(acc_sh);
        end
        assign y_abs = y[NORM_W-1] ? NORM_W'(-y) : y;

        always_ff @(posedge clk_sys) begin
            if (coef_wr && coef_ch == CH_W'(c) && {1'b0, coef_idx} < 9'(TAPS)) begin
                coef_mem[TAP_W'(coef_idx)] <= coef_data;
            end
            if (st_r == ST_STORE) res_mem[n_r] <= y;
            rd_r <= res_mem[res_rd_idx];
        end

        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                acc_r <= '0;
            end else if (st_r == ST_LOAD) begin
                acc_r <= '0;
            end else if (st_r == ST_MAC) begin
                acc_r <= acc_r + ACC_W'(coef_mem[k_r] * hist_r[k_r]);
            end
        end

        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                blk_sum_r <= '0;
                total_r <= '0;
            end else if (st_r == ST_STORE) begin
                blk_sum_r <= blk_sum_r + SUM_W'(y_abs);
            end else if (st_r == ST_BLOCKEND) begin
                blk_sum_r <= '0;
                total_r <= total_r + TOTAL_W'(blk_sum_r >> BLOCK_SHIFT);
            end else if (st_r == ST_JUDGE) begin
                total_r <= '0;
            end
        end

        assign total[c] = total_r;
        assign rd_word[c] = rd_r;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            res_rd_data <= '0;
        end else begin
            res_rd_data <= (res_rd_ch < CH_W'(NUM_CH)) ? rd_word[res_rd_ch] : '0;
        end
    end

    // Decision: a band needs a strictly largest total
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            band_r <= BAND_NONE;
        end else if (st_r == ST_JUDGE) begin
            if (total[0] > total[1] && total[0] > total[2]) band_r <= BAND_LOW;
            else if (total[1] > total[0] && total[1] > total[2]) band_r <= BAND_MID;
            else if (total[2] > total[0] && total[2] > total[1]) band_r <= BAND_HIGH;
            else band_r <= BAND_NONE;
        end
    end

    assign band_indicator_a = (band_r == BAND_LOW) || (band_r == BAND_HIGH);
    assign band_indicator_b = (band_r == BAND_MID) || (band_r == BAND_HIGH);
    assign filter_on = filter_on_r;
    assign overrun = overrun_r;

    sequence seq_handler;
        blk_take;
    endsequence
    sequence seq_service;
        st_r == ST_UPDATE ##1 st_r == ST_LOAD;
    endsequence

    AST_SWAP: assert property (blk_take |=> cur_base_r == $past(next_base_r))
        else $error("active descriptor not taken from pending one");
    AST_HOLD: assert property (block_done && !blk_take
        |=> $stable(cur_base_r) && $stable(job_base_r))
        else $error("dropped block moved the descriptors");
    AST_ORDER: assert property (seq_handler |=> ##1 seq_service)
        else $error("filter did not follow completion handling");
    AST_REQ: assert property (block_done |=> update_req_r)
        else $error("update flag not set on block end");
    AST_SERVICE: assert property (st_r == ST_UPDATE && update_req_r && !block_done
        |=> !update_req_r && next_base_r != cur_base_r && next_cnt_r == DESC_CNT_RST)
        else $error("pending descriptor not refreshed");
    AST_INIT: assert property (st_r == ST_INIT |-> !xfer_en_r && !update_req_r)
        else $error("transfer active or flag set during init");
    AST_PINGPONG: assert property (st_r inside {ST_LOAD, ST_MAC, ST_STORE}
        |-> job_base_r != cur_base_r)
        else $error("filter reads the block being filled");
    AST_TOGGLE: assert property (btn_rise |=> filter_on_r != $past(filter_on_r))
        else $error("press did not toggle filter");
    AST_CLEAR: assert property (st_r == ST_JUDGE |=> blk_cnt_r == '0 && total[0] == '0
        && total[1] == '0 && total[2] == '0)
        else $error("window not cleared after decision");
    AST_TIE: assert property (st_r == ST_JUDGE && total[0] == total[1]
        && total[2] <= total[0] |=> band_r == BAND_NONE)
        else $error("tie not reported undecidable");
    AST_LED: assert property ($changed(band_r) |-> $past(st_r) == ST_JUDGE)
        else $error("band changed outside decision");
endmodule : three_band_fir_judge

// >>> src/three_band_pkg.sv
package three_band_pkg;
    localparam int SAMPLE_W = 12;
    localparam int NORM_W = 16;
    localparam int WORD_W = 32;
    localparam int BLOCK_LEN = 256;
    localparam int BLOCK_SHIFT = 8;
    localparam int IDX_W = 9;
    localparam int ADDR_W = 9;
    localparam int NUM_CH = 3;
    localparam int CH_W = 2;
    localparam int DEFAULT_TAPS = 64;
    localparam int BLOCKS_PER_DECISION = 40;
    localparam int BLK_CNT_W = 6;
    localparam int SAMPLE_RATE_HZ = 10000;
    localparam int LPF_CUTOFF_HZ = 500;
    localparam int BPF_CENTER_HZ = 1500;
    localparam int HPF_CUTOFF_HZ = 3000;
    localparam int ACC_W = 40;
    localparam int SUM_W = 24;
    localparam int TOTAL_W = 24;
    localparam int COEF_FRAC = 15;
    localparam int NORM_SHIFT16 = 3;
    localparam int NORM_SHIFT32 = 19;
    localparam logic [SAMPLE_W-1:0] ADC_BIAS = 12'h800;
    localparam logic [ADDR_W-1:0] NEXT_BASE_RST = 9'h100;
    localparam logic [ADDR_W-1:0] CUR_BASE_RST = 9'h000;
    localparam logic [IDX_W-1:0] DESC_CNT_RST = 9'h100;
    localparam logic [ADDR_W-1:0] BLOCK_SEL = 9'h100;
    localparam logic [7:0] F32_EXP_ONE = 8'h7f;
    localparam logic [15:0] SAT_POS = 16'h7fff;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam logic SRC_STORED = 1'b1;
    localparam int WAVE_LEN = 16;
    localparam int WAVE_W = 4;
    localparam logic [SAMPLE_W-1:0] WAVE_TABLE [WAVE_LEN] = '{
        12'h800, 12'hb0f, 12'hda8, 12'hf64, 12'hfff, 12'hf64, 12'hda8, 12'hb0f,
        12'h800, 12'h4f1, 12'h258, 12'h09c, 12'h001, 12'h09c, 12'h258, 12'h4f1};
    typedef enum logic [1:0] {
        NORM_I16 = 2'h0,
        NORM_I32 = 2'h1,
        NORM_F32 = 2'h2
    } norm_mode_t;
    typedef enum logic [1:0] {
        BAND_NONE = 2'h0,
        BAND_LOW = 2'h1,
        BAND_MID = 2'h2,
        BAND_HIGH = 2'h3
    } band_t;
endpackage : three_band_pkg

// >>> tb/sample_source.sv
`timescale 1ns/100ps
module sample_source (
    input wire logic clk_sys,
    output logic sample_valid,
    output logic [three_band_pkg::SAMPLE_W-1:0] sample_data
);
    import three_band_pkg::*;
    initial begin
        sample_valid = 1'b0;
        sample_data = 12'h5a5;
    end
    // Called at a falling edge; gap 0 keeps the strobe up for a back-to-back sample
    task automatic send(input logic [SAMPLE_W-1:0] v, input int gap);
        sample_valid = 1'b1;
        sample_data = v;
        @(negedge clk_sys);
        if (gap > 0) begin
            // Released data line shows the inverse, not the last value
            sample_valid = 1'b0;
            sample_data = ~v;
            repeat (gap) @(negedge clk_sys);
        end
    endtask : send
endmodule : sample_source

// >>> tb/three_band_fir_judge_tb_top.sv
`timescale 1ns/100ps
module three_band_fir_judge_tb_top;
    import three_band_pkg::*;
    localparam int TAPS = 64;
    localparam int LIMIT = 95000;
    logic clk_sys, nrst, sample_valid, sample_ready, source_select, coef_wr, coef_load_done;
    logic filter_toggle_button, norm_valid, filter_on, overrun, band_indicator_a, band_indicator_b;
    logic [SAMPLE_W-1:0] sample_data;
    norm_mode_t norm_mode;
    logic [CH_W-1:0] coef_ch, res_rd_ch;
    logic [7:0] coef_idx, res_rd_idx;
    logic signed [NORM_W-1:0] coef_data;
    logic [NORM_W-1:0] res_rd_data;
    logic [WORD_W-1:0] norm_word;
    logic [SAMPLE_W-1:0] blk [BLOCK_LEN];
    logic [WORD_W-1:0] got [$];
    logic [15:0] coef_set [NUM_CH] = '{16'h4000, 16'hc000, 16'h7fff};
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int ovr_cnt = 0;
    bit found, ok;

    three_band_fir_judge #(.TAPS(TAPS)) three_band_fir_judge_i (
        .clk_sys(clk_sys), .nrst(nrst), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_ready(sample_ready),
        .source_select(source_select), .norm_mode(norm_mode), .coef_wr(coef_wr),
        .coef_ch(coef_ch), .coef_idx(coef_idx), .coef_data(coef_data),
        .coef_load_done(coef_load_done), .filter_toggle_button(filter_toggle_button),
        .res_rd_ch(res_rd_ch), .res_rd_idx(res_rd_idx), .res_rd_data(res_rd_data),
        .norm_word(norm_word), .norm_valid(norm_valid), .filter_on(filter_on),
        .overrun(overrun), .band_indicator_a(band_indicator_a),
        .band_indicator_b(band_indicator_b)
    );
    sample_source sample_source_i (
        .clk_sys(clk_sys), .sample_valid(sample_valid), .sample_data(sample_data)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (norm_valid === 1'b1) got.push_back(norm_word);
        if (overrun === 1'b1) ovr_cnt <= ovr_cnt + 1;
        if (cyc == LIMIT) begin
            err_total++;
            $display("unexpected at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic chk1(input logic g, input logic e, input string what);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, g, e);
        end
    endtask : chk1
    task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask : chk16
    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask : chk32
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask : end_test

    function automatic logic [15:0] n16(input logic [11:0] x);
        return 16'((int'(x) - 2048) * 8);
    endfunction : n16
    function automatic logic [31:0] n32(input logic [11:0] x);
        return 32'((int'(x) - 2048) * 524288);
    endfunction : n32
    function automatic logic [31:0] nf(input logic [11:0] x);
        int v, m, e;
        v = int'(x) - 2048;
        m = (v < 0) ? -v : v;
        e = 0;
        if (m == 0) return 32'h0;
        while ((m >> (e + 1)) != 0) e++;
        return {1'(v < 0), 8'(127 + e - 11), 23'(m << (23 - e))};
    endfunction : nf
    function automatic logic [15:0] fir(input logic [15:0] n, input logic [15:0] c);
        return 16'((int'($signed(n)) * int'($signed(c))) >>> 15);
    endfunction : fir

    task automatic wr_coef(input int c, input int t, input logic [15:0] d);
        coef_wr = 1'b1;
        coef_ch = CH_W'(c);
        coef_idx = 8'(t);
        coef_data = d;
        @(negedge clk_sys);
        coef_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr_coef
    task automatic fill_push();
        for (int i = 0; i < BLOCK_LEN; i++) blk[i] = 12'($urandom);
        blk[0] = 12'h000;
        blk[1] = 12'h800;
        blk[BLOCK_LEN-1] = 12'hfff;
        for (int i = 0; i < BLOCK_LEN; i++)
            sample_source_i.send(blk[i], (i == BLOCK_LEN - 1) ? 1 : int'($urandom_range(2)));
    endtask : fill_push
    task automatic wait_norm();
        int n;
        n = 0;
        while (got.size() < BLOCK_LEN && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        chk1(got.size() == BLOCK_LEN, 1'b1, "normalised count");
        repeat (TAPS + 8) @(negedge clk_sys);
    endtask : wait_norm
    task automatic chk_res(input bit off);
        logic [15:0] e;
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < BLOCK_LEN; i++) begin
                res_rd_ch = CH_W'(c);
                res_rd_idx = 8'(i);
                repeat (2) @(negedge clk_sys);
                e = (c == 3) ? 16'h0 : off ? n16(blk[i]) : fir(n16(blk[i]), coef_set[c]);
                chk16(res_rd_data, e, "result");
            end
        end
    endtask : chk_res

    initial begin
        nrst = 1'b0;
        source_select = 1'b0;
        norm_mode = NORM_I16;
        coef_wr = 1'b0;
        coef_ch = '0;
        coef_idx = 8'h00;
        coef_data = 16'h0000;
        coef_load_done = 1'b0;
        filter_toggle_button = 1'b0;
        res_rd_ch = '0;
        res_rd_idx = 8'h00;
        void'($urandom(28478));
        repeat (8) @(negedge clk_sys);
        chk1(filter_on, 1'b1, "filter on in reset");
        nrst = 1'b1;
        // Samples offered before the load is done must be dropped
        repeat (4) sample_source_i.send(12'h123, 1);
        chk1(sample_ready, 1'b0, "ready before load");
        for (int c = 0; c < NUM_CH; c++)
            for (int t = 0; t < TAPS; t++) wr_coef(c, t, (t == 0) ? coef_set[c] : 16'h0);
        wr_coef(0, TAPS, 16'h2000);
        coef_load_done = 1'b1;
        @(negedge clk_sys);
        chk1(sample_ready, 1'b1, "ready after load");
        end_test("init");
        fill_push();
        wait_norm();
        for (int i = 0; i < BLOCK_LEN; i++) chk16(got[i][15:0], n16(blk[i]), "norm16");
        chk_res(1'b0);
        got.delete();
        end_test("int16 block");
        norm_mode = NORM_I32;
        source_select = SRC_STORED;
        fill_push();
        wait_norm();
        found = 1'b0;
        for (int k = 0; k < WAVE_LEN; k++) begin
            ok = 1'b1;
            for (int i = 0; i < BLOCK_LEN; i++)
                if (got[i] !== n32(WAVE_TABLE[(k + i) % WAVE_LEN])) ok = 1'b0;
            if (ok) found = 1'b1;
        end
        chk1(found, 1'b1, "stored wave as int32");
        got.delete();
        source_select = 1'b0;
        end_test("stored int32 block");
        norm_mode = NORM_F32;
        fill_push();
        wait_norm();
        for (int i = 0; i < BLOCK_LEN; i++) chk32(got[i], nf(blk[i]), "float");
        got.delete();
        end_test("float block");
        norm_mode = NORM_I16;
        filter_toggle_button = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk1(filter_on, 1'b1, "toggle too early");
        @(negedge clk_sys);
        chk1(filter_on, 1'b0, "toggle off");
        filter_toggle_button = 1'b0;
        fill_push();
        // A second block ending during filtering is flagged and dropped
        for (int i = 0; i < BLOCK_LEN; i++)
            sample_source_i.send(12'($urandom), (i == BLOCK_LEN - 1) ? 1 : 0);
        wait_norm();
        chk_res(1'b1);
        repeat (300) @(negedge clk_sys);
        chk1(ovr_cnt == 1, 1'b1, "overrun pulse");
        chk1(got.size() == BLOCK_LEN, 1'b1, "dropped block");
        chk1(band_indicator_a | band_indicator_b, 1'b0, "no early band");
        end_test("filter off and overrun");
        close_out();
    end
endmodule : three_band_fir_judge_tb_top
